/* logic/scale_alarm_pkg.sv */
// shared types and constants for the analog channel scaling/output block
`default_nettype none
package scale_alarm_pkg;
	// ==========================================================
	// data format
	localparam int DATA_W = 32;
	typedef logic signed [DATA_W-1:0] value_t;
	localparam value_t VALUE_RST = 32'h0000_0000;

	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int RAMP_TICK_NS = 1000000; // one ramp step per ms
	localparam int RAMP_TICK_CYCLES = RAMP_TICK_NS / CLK_PERIOD_NS;
	localparam int RAMP_TICKS_PER_SEC = 1000000000 / RAMP_TICK_NS;
	localparam int PERCENT_FULL = 100;
	localparam int MATCH_TOL_DIV = 1000; // 0.1 % of full scale

	// ==========================================================
	// input channel configuration
	typedef struct packed {
		value_t scale_signal_upper_point;
		value_t scale_signal_lower_point;
		value_t scale_eng_upper_point;
		value_t scale_eng_lower_point;
		value_t calibration_offset;
		value_t lo_alarm_threshold;
		value_t hi_alarm_threshold;
		value_t lolo_alarm_threshold;
		value_t hihi_alarm_threshold;
		value_t alarm_hysteresis;
	} in_cfg_t;

	typedef struct packed {
		logic lo_alarm_flag;
		logic hi_alarm_flag;
		logic lolo_alarm_flag;
		logic hihi_alarm_flag;
	} in_alarm_t;

	// ==========================================================
	// output channel configuration
	typedef struct packed {
		logic hold_until_matched;
		logic rate_alarm_latch_en;
		logic clamp_alarm_latch_en;
		logic comm_loss_action_sel;
		logic idle_action_sel;
		logic slew_in_run_en;
		logic slew_to_idle_en;
		logic slew_to_comm_loss_en;
		logic [15:0] slew_rate_limit;
		value_t comm_loss_output_value;
		value_t idle_output_value;
		value_t output_floor;
		value_t output_ceiling;
	} out_cfg_t;

	typedef struct packed {
		logic floor_clamp_flag;
		logic ceiling_clamp_flag;
		logic rate_alarm_flag;
	} out_alarm_t;

	typedef enum logic [1:0] {
		UNLATCH_FLOOR,
		UNLATCH_CEILING,
		UNLATCH_RATE,
		UNLATCH_ALL
	} unlatch_sel_t;
endpackage
`default_nettype wire

/* logic/analog_channel_scale_alarm_ramp.sv */
// one input channel (scale, bias, alarms) and one output channel
// (clamp, fault/program actions, ramp, hold for init)
//
// Contract
// - input data = (sig-lo_sig)*(hi_eng-lo_eng)/(hi_sig-lo_sig)+lo_eng.
// - low alarm sets when scaled value falls below low threshold.
// - high alarm sets when scaled value rises above high threshold.
// - low-low alarm sets when scaled value falls below low-low threshold.
// - high-high alarm sets when value rises above high-high threshold.
// - alarm stays set until value passes back beyond trigger by hysteresis.
// - calibration offset is added directly to the reported value.
// - hold output after init, program-to-run or fault recovery until match.
// - latched rate alarm stays set until an unlatch service arrives.
// - latched clamp alarms stay set until an unlatch service arrives.
// - on comm loss hold last value, or go to comm loss value.
// - in program mode hold last value, or go to idle value.
// - run-mode ramping limits slew toward new request.
// - ramping toward idle value is rate limited.
// - ramping toward comm loss value is rate limited.
// - slew limit is integer percent of full scale per second.
// - request below floor sets floor flag and drives floor.
// - request above ceiling sets ceiling flag and drives ceiling.
// - each unlatch clears once; recurring condition sets the flag again.
// - unlatch services wait for cycles free of sample and request work.
`timescale 1ns/100ps
`default_nettype none
module analog_channel_scale_alarm_ramp #(
	parameter int RAMP_TICK_CYCLES = scale_alarm_pkg::RAMP_TICK_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// input channel
	input wire logic sample_valid,
	input wire scale_alarm_pkg::value_t sample_signal,
	input wire scale_alarm_pkg::in_cfg_t in_cfg,
	output scale_alarm_pkg::value_t channel_value,
	output logic channel_value_valid,
	output scale_alarm_pkg::in_alarm_t in_alarms,
	// output channel
	input wire logic request_valid,
	input wire scale_alarm_pkg::value_t request_value,
	input wire logic run_mode,
	input wire logic comm_ok,
	input wire scale_alarm_pkg::out_cfg_t out_cfg,
	output scale_alarm_pkg::value_t drive_value,
	output scale_alarm_pkg::out_alarm_t out_alarms,
	output logic holding_for_init,
	// unlatch service
	input wire logic unlatch_req,
	input wire scale_alarm_pkg::unlatch_sel_t unlatch_sel,
	output logic unlatch_done
);
	// a tick period below one cycle cannot be counted by the divider
	if (RAMP_TICK_CYCLES < 1) begin : g_tick_check
		$error("RAMP_TICK_CYCLES must be at least 1");
	end

	typedef logic signed [scale_alarm_pkg::DATA_W+1:0] wide_t;
	typedef logic signed [2*scale_alarm_pkg::DATA_W+3:0] prod_t;

	// value beyond a low threshold test, with hysteresis on the way back
	function automatic logic lo_alarm(input logic cur, input wide_t v,
		input wide_t th, input wide_t h);
		if (v < th)
			lo_alarm = 1'b1;
		else if (v > th + h)
			lo_alarm = 1'b0;
		else
			lo_alarm = cur;
	endfunction

	function automatic logic hi_alarm(input logic cur, input wide_t v,
		input wide_t th, input wide_t h);
		if (v > th)
			hi_alarm = 1'b1;
		else if (v < th - h)
			hi_alarm = 1'b0;
		else
			hi_alarm = cur;
	endfunction

	// sticky when latching, following the condition otherwise; set wins
	function automatic logic flag_next(input logic cur, input logic cond,
		input logic latch, input logic clr);
		if (cond)
			flag_next = 1'b1;
		else if (latch)
			flag_next = cur & ~clr;
		else
			flag_next = 1'b0;
	endfunction

	// ==========================================================
	// input scaling
	wide_t sig_w, ls_w, hs_w, le_w, he_w, cal_w, hyst_w, scaled_w;
	prod_t num, quo;
	scale_alarm_pkg::value_t scaled;
	scale_alarm_pkg::value_t channel_value_q;
	logic channel_value_valid_q;
	scale_alarm_pkg::in_alarm_t in_alarms_q;

	assign sig_w = wide_t'(sample_signal);
	assign ls_w = wide_t'(in_cfg.scale_signal_lower_point);
	assign hs_w = wide_t'(in_cfg.scale_signal_upper_point);
	assign le_w = wide_t'(in_cfg.scale_eng_lower_point);
	assign he_w = wide_t'(in_cfg.scale_eng_upper_point);
	assign cal_w = wide_t'(in_cfg.calibration_offset);
	assign hyst_w = wide_t'(in_cfg.alarm_hysteresis);

	// a zero signal span would divide by zero; report the engineering low point plus the calibration offset then
	always_comb begin
		num = prod_t'(sig_w - ls_w) * prod_t'(he_w - le_w);
		if (hs_w == ls_w)
			quo = '0;
		else
			quo = num / prod_t'(hs_w - ls_w);
		scaled_w = wide_t'(quo) + le_w + cal_w;
		scaled = scaled_w[scale_alarm_pkg::DATA_W-1:0];
	end

	// reported value, one cycle after the sample
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			channel_value_q <= scale_alarm_pkg::VALUE_RST;
			channel_value_valid_q <= 1'b0;
		end else begin
			channel_value_valid_q <= sample_valid;
			if (sample_valid)
				channel_value_q <= scaled;
		end
	end

	// process alarms on every sample
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			in_alarms_q <= '0;
		end else if (sample_valid) begin
			in_alarms_q.lo_alarm_flag <= lo_alarm(in_alarms_q.lo_alarm_flag,
				scaled_w, wide_t'(in_cfg.lo_alarm_threshold),
				hyst_w);
			in_alarms_q.hi_alarm_flag <= hi_alarm(in_alarms_q.hi_alarm_flag,
				scaled_w, wide_t'(in_cfg.hi_alarm_threshold),
				hyst_w);
			in_alarms_q.lolo_alarm_flag <= lo_alarm(
				in_alarms_q.lolo_alarm_flag, scaled_w,
				wide_t'(in_cfg.lolo_alarm_threshold), hyst_w);
			in_alarms_q.hihi_alarm_flag <= hi_alarm(
				in_alarms_q.hihi_alarm_flag, scaled_w,
				wide_t'(in_cfg.hihi_alarm_threshold), hyst_w);
		end
	end

	// ==========================================================
	// unlatch service, deferred behind real-time work
	logic unlatch_pend_q;
	scale_alarm_pkg::unlatch_sel_t unlatch_sel_q;
	logic unlatch_go;
	logic unlatch_done_q;

	assign unlatch_go = unlatch_pend_q & ~sample_valid
		& ~request_valid;

	// a request during a pending one replaces it: one service at a time
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			unlatch_pend_q <= 1'b0;
			unlatch_sel_q <= scale_alarm_pkg::UNLATCH_FLOOR;
			unlatch_done_q <= 1'b0;
		end else begin
			unlatch_done_q <= unlatch_go;
			if (unlatch_req) begin
				unlatch_pend_q <= 1'b1;
				unlatch_sel_q <= unlatch_sel;
			end else if (unlatch_go) begin
				unlatch_pend_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// ramp tick divider
	logic [31:0] tick_cnt_q;
	logic tick;

	assign tick = (tick_cnt_q == 32'(RAMP_TICK_CYCLES - 1));

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			tick_cnt_q <= '0;
		else if (tick)
			tick_cnt_q <= '0;
		else
			tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
	end

	// ==========================================================
	// output channel
	typedef enum logic [1:0] {
		ST_HOLD_INIT,
		ST_RUN,
		ST_IDLE,
		ST_COMM_LOSS
	} out_state_t;

	out_state_t state_q;
	scale_alarm_pkg::value_t req_q, drive_q, clamped, target;
	scale_alarm_pkg::out_alarm_t out_alarms_q;
	wide_t flr_w, ceil_w, req_w, drv_w, span_w, tol_w, diff_w, step_w;
	prod_t step_p;
	logic below, above, matched, ramp_en, limited;
	logic clr_floor, clr_ceil, clr_rate;

	assign flr_w = wide_t'(out_cfg.output_floor);
	assign ceil_w = wide_t'(out_cfg.output_ceiling);
	assign req_w = wide_t'(req_q);
	assign drv_w = wide_t'(drive_q);
	assign span_w = ceil_w - flr_w; // full scale of the channel
	assign below = req_w < flr_w;
	assign above = req_w > ceil_w;
	assign tol_w = span_w / wide_t'(scale_alarm_pkg::MATCH_TOL_DIV);
	assign diff_w = (req_w > drv_w) ? req_w - drv_w : drv_w - req_w;
	assign matched = diff_w <= tol_w;

	// percent per second spread over ramp ticks, at least one unit
	always_comb begin
		step_p = prod_t'(span_w) * prod_t'(out_cfg.slew_rate_limit)
			/ prod_t'(scale_alarm_pkg::PERCENT_FULL
			* scale_alarm_pkg::RAMP_TICKS_PER_SEC);
		step_w = (step_p < prod_t'(1)) ? wide_t'(1) : wide_t'(step_p);
	end

	// clamp the request into the permitted band
	always_comb begin
		if (below)
			clamped = out_cfg.output_floor;
		else if (above)
			clamped = out_cfg.output_ceiling;
		else
			clamped = req_q;
	end

	// target and ramp choice per mode; hold-last keeps the present level
	always_comb begin
		target = drive_q;
		ramp_en = 1'b0;
		case (state_q)
			ST_RUN: begin
				target = clamped;
				ramp_en = out_cfg.slew_in_run_en;
			end
			ST_IDLE: begin
				if (out_cfg.idle_action_sel)
					target = out_cfg.idle_output_value;
				ramp_en = out_cfg.slew_to_idle_en;
			end
			ST_COMM_LOSS: begin
				if (out_cfg.comm_loss_action_sel)
					target = out_cfg.comm_loss_output_value;
				ramp_en = out_cfg.slew_to_comm_loss_en;
			end
			default: begin
				target = drive_q;
				ramp_en = 1'b0;
			end
		endcase
	end

	assign limited = (state_q == ST_RUN) && ramp_en
		&& (target != drive_q);

	// latest request, taken in every mode
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			req_q <= scale_alarm_pkg::VALUE_RST;
		else if (request_valid)
			req_q <= request_value;
	end

	// mode sequencing; comm loss takes precedence over program mode
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ST_HOLD_INIT;
		end else begin
			case (state_q)
				ST_HOLD_INIT: begin
					if (!comm_ok)
						state_q <= ST_COMM_LOSS;
					else if (!run_mode)
						state_q <= ST_IDLE;
					else if (!out_cfg.hold_until_matched || matched)
						state_q <= ST_RUN;
				end
				ST_RUN: begin
					if (!comm_ok)
						state_q <= ST_COMM_LOSS;
					else if (!run_mode)
						state_q <= ST_IDLE;
				end
				ST_IDLE: begin
					if (!comm_ok)
						state_q <= ST_COMM_LOSS;
					else if (run_mode)
						state_q <= out_cfg.hold_until_matched
							? ST_HOLD_INIT : ST_RUN;
				end
				ST_COMM_LOSS: begin
					if (comm_ok && !run_mode)
						state_q <= ST_IDLE;
					else if (comm_ok)
						state_q <= out_cfg.hold_until_matched
							? ST_HOLD_INIT : ST_RUN;
				end
				default: state_q <= ST_HOLD_INIT;
			endcase
		end
	end

	// output level: immediate, or one bounded step per ramp tick
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			drive_q <= scale_alarm_pkg::VALUE_RST;
		end else if (!ramp_en) begin
			drive_q <= target;
		end else if (tick) begin
			if (wide_t'(target) > drv_w + step_w)
				drive_q <= scale_alarm_pkg::value_t'(drv_w + step_w);
			else if (wide_t'(target) < drv_w - step_w)
				drive_q <= scale_alarm_pkg::value_t'(drv_w - step_w);
			else
				drive_q <= target;
		end
	end

	// clears decoded from the served unlatch service
	always_comb begin
		clr_floor = unlatch_go && (unlatch_sel_q == scale_alarm_pkg::UNLATCH_FLOOR
			|| unlatch_sel_q == scale_alarm_pkg::UNLATCH_ALL);
		clr_ceil = unlatch_go
			&& (unlatch_sel_q == scale_alarm_pkg::UNLATCH_CEILING
			|| unlatch_sel_q == scale_alarm_pkg::UNLATCH_ALL);
		clr_rate = unlatch_go && (unlatch_sel_q == scale_alarm_pkg::UNLATCH_RATE
			|| unlatch_sel_q == scale_alarm_pkg::UNLATCH_ALL);
	end

	// clamp flags judge run-mode requests only; rate flag marks run-mode slewing only
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			out_alarms_q <= '0;
		end else begin
			out_alarms_q.floor_clamp_flag <= flag_next(
				out_alarms_q.floor_clamp_flag, below && state_q == ST_RUN,
				out_cfg.clamp_alarm_latch_en, clr_floor);
			out_alarms_q.ceiling_clamp_flag <= flag_next(
				out_alarms_q.ceiling_clamp_flag, above && state_q == ST_RUN,
				out_cfg.clamp_alarm_latch_en, clr_ceil);
			out_alarms_q.rate_alarm_flag <= flag_next(
				out_alarms_q.rate_alarm_flag, limited,
				out_cfg.rate_alarm_latch_en, clr_rate);
		end
	end

	// ==========================================================
	// outputs
	assign channel_value = channel_value_q;
	assign channel_value_valid = channel_value_valid_q;
	assign in_alarms = in_alarms_q;
	assign drive_value = drive_q;
	assign out_alarms = out_alarms_q;
	assign holding_for_init = (state_q == ST_HOLD_INIT);
	assign unlatch_done = unlatch_done_q;
endmodule // analog_channel_scale_alarm_ramp
`default_nettype wire

/* verif/analog_channel_scale_alarm_ramp_props.sv */
// checker: port-level assertions for the channel block
`timescale 1ns/100ps
`default_nettype none
module analog_channel_scale_alarm_ramp_props #(
	parameter int RAMP_TICK_CYCLES = scale_alarm_pkg::RAMP_TICK_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// input channel
	input wire logic sample_valid,
	input wire scale_alarm_pkg::in_cfg_t in_cfg,
	input wire scale_alarm_pkg::value_t channel_value,
	input wire logic channel_value_valid,
	input wire scale_alarm_pkg::in_alarm_t in_alarms,
	// output channel
	input wire logic request_valid,
	input wire logic run_mode,
	input wire logic comm_ok,
	input wire scale_alarm_pkg::out_cfg_t out_cfg,
	input wire scale_alarm_pkg::value_t drive_value,
	input wire scale_alarm_pkg::out_alarm_t out_alarms,
	input wire logic holding_for_init,
	input wire logic unlatch_done
);
	// ==========================================================
	// one clock domain, so clock and reset are given once
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	// four quiet cycles of comm loss with hold-last selected
	sequence s_hold_last;
		(!comm_ok && !out_cfg.comm_loss_action_sel)[*4];
	endsequence

	// ==========================================================
	// input channel
	a_sample_answer: assert property (
		sample_valid |=> channel_value_valid)
		else $error("no valid after sample");
	a_lo_set: assert property (
		channel_value_valid && channel_value < in_cfg.lo_alarm_threshold
		|-> in_alarms.lo_alarm_flag)
		else $error("low alarm missing");
	a_hihi_set: assert property (
		channel_value_valid && channel_value > in_cfg.hihi_alarm_threshold
		|-> in_alarms.hihi_alarm_flag)
		else $error("high-high alarm missing");
	// a release inside the band would chatter on a noisy input
	a_lo_release: assert property (
		$fell(in_alarms.lo_alarm_flag) |-> channel_value >
		in_cfg.lo_alarm_threshold + in_cfg.alarm_hysteresis)
		else $error("low alarm released inside band");

	// ==========================================================
	// output channel
	a_hold_frozen: assert property (
		holding_for_init && $past(holding_for_init)
		|-> $stable(drive_value))
		else $error("output moved while holding");
	a_rate_latched: assert property (
		out_cfg.rate_alarm_latch_en && out_alarms.rate_alarm_flag
		|=> out_alarms.rate_alarm_flag || unlatch_done)
		else $error("latched rate flag dropped");
	a_floor_latched: assert property (
		out_cfg.clamp_alarm_latch_en && out_alarms.floor_clamp_flag
		|=> out_alarms.floor_clamp_flag || unlatch_done)
		else $error("latched floor flag dropped");
	a_comm_hold: assert property (
		s_hold_last |-> $stable(drive_value))
		else $error("output moved in comm loss hold");
	a_drive_band: assert property (
		run_mode && comm_ok && !holding_for_init
		|-> drive_value >= out_cfg.output_floor
		&& drive_value <= out_cfg.output_ceiling)
		else $error("output outside limits");
	// services use only cycles free of sample and request work
	a_unlatch_idle: assert property (
		unlatch_done |-> !$past(sample_valid) && !$past(request_valid))
		else $error("unlatch applied in a busy cycle");
endmodule // analog_channel_scale_alarm_ramp_props

bind analog_channel_scale_alarm_ramp analog_channel_scale_alarm_ramp_props
	#(.RAMP_TICK_CYCLES(RAMP_TICK_CYCLES)) u_props (
	.clk(clk), .reset_n(reset_n), .sample_valid(sample_valid),
	.in_cfg(in_cfg), .channel_value(channel_value),
	.channel_value_valid(channel_value_valid), .in_alarms(in_alarms),
	.request_valid(request_valid), .run_mode(run_mode), .comm_ok(comm_ok),
	.out_cfg(out_cfg), .drive_value(drive_value), .out_alarms(out_alarms),
	.holding_for_init(holding_for_init), .unlatch_done(unlatch_done));
`default_nettype wire

/* verif/supervisor_model.sv */
// partner: supervising controller sending output requests and unlatches
`timescale 1ns/100ps
`default_nettype none
module supervisor_model (
	// clock
	input wire logic clk,
	// requests and services
	output logic request_valid,
	output scale_alarm_pkg::value_t request_value,
	output logic unlatch_req,
	output scale_alarm_pkg::unlatch_sel_t unlatch_sel,
	// service completion
	input wire logic unlatch_done
);
	// quiet at time zero
	initial begin
		request_valid = 1'b0;
		request_value = 32'h0;
		unlatch_req = 1'b0;
		unlatch_sel = scale_alarm_pkg::UNLATCH_ALL;
	end

	// one request held across one rising edge; stale data is inverted
	task automatic send(input scale_alarm_pkg::value_t v);
		@(negedge clk);
		request_valid = 1'b1;
		request_value = v;
		@(negedge clk);
		request_valid = 1'b0;
		request_value = ~v;
	endtask

	// one service clears once; a recurring alarm needs a new one
	task automatic unlatch(input scale_alarm_pkg::unlatch_sel_t s,
		output bit ok);
		ok = 1'b0;
		@(negedge clk);
		unlatch_req = 1'b1;
		unlatch_sel = s;
		@(negedge clk);
		unlatch_req = 1'b0;
		for (int i = 0; i < 20 && !ok; i++) begin
			@(negedge clk);
			ok = (unlatch_done === 1'b1);
		end
	endtask
endmodule // supervisor_model
`default_nettype wire

/* verif/analog_channel_scale_alarm_ramp_tb_top.sv */
// testbench: scaling, alarms, clamps, modes, latches and ramps
`timescale 1ns/100ps
`default_nettype none
module analog_channel_scale_alarm_ramp_tb_top;
	// ==========================================================
	// short tick keeps ramps brief; step = 1100 span * 1000 / 100000
	localparam int TICK = 8;
	localparam int STEP = 11;
	logic clk, reset_n, sample_valid, valid, request_valid, run_mode;
	logic comm_ok, holding, unlatch_req, unlatch_done;
	scale_alarm_pkg::value_t sample_signal, chan, request_value, drive;
	scale_alarm_pkg::in_cfg_t ic;
	scale_alarm_pkg::out_cfg_t oc;
	scale_alarm_pkg::in_alarm_t in_al;
	scale_alarm_pkg::out_alarm_t out_al;
	scale_alarm_pkg::unlatch_sel_t unlatch_sel;
	int n_fail = 0;
	int compares = 0;
	bit ok;

	// clock
	always #2 clk = ~clk;

	analog_channel_scale_alarm_ramp #(.RAMP_TICK_CYCLES(TICK)) dut (
		.clk(clk), .reset_n(reset_n), .sample_valid(sample_valid),
		.sample_signal(sample_signal), .in_cfg(ic), .channel_value(chan),
		.channel_value_valid(valid), .in_alarms(in_al),
		.request_valid(request_valid), .request_value(request_value),
		.run_mode(run_mode), .comm_ok(comm_ok), .out_cfg(oc),
		.drive_value(drive), .out_alarms(out_al),
		.holding_for_init(holding), .unlatch_req(unlatch_req),
		.unlatch_sel(unlatch_sel), .unlatch_done(unlatch_done));

	supervisor_model ctl (
		.clk(clk), .request_valid(request_valid),
		.request_value(request_value), .unlatch_req(unlatch_req),
		.unlatch_sel(unlatch_sel), .unlatch_done(unlatch_done));

	// ==========================================================
	// shared helpers
	task automatic results();
		$display("compares %0d, n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] g,
		input logic [31:0] e);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s: expected %h, seen %h", n, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	// drive follows two edges after the request; two cycles of margin
	task automatic req(input scale_alarm_pkg::value_t v);
		ctl.send(v);
		cyc(3);
	endtask
	task automatic unl(input scale_alarm_pkg::unlatch_sel_t s);
		ctl.unlatch(s, ok);
		chk("unlatch done", ok, 1'b1);
		if (!ok) results();
	endtask
	// a jump larger than one step per move shows a missing rate limit
	task automatic watch(input scale_alarm_pkg::value_t t);
		scale_alarm_pkg::value_t p;
		int n;
		int d;
		int lo;
		p = drive;
		n = 0;
		d = (t > drive) ? t - drive : drive - t;
		// every step but the first waits a whole tick
		lo = ((d + STEP - 1) / STEP - 1) * TICK + 1;
		for (int i = 0; i < 400 && drive !== t; i++) begin
			@(negedge clk);
			n++;
			if (drive - p > STEP || p - drive > STEP)
				chk("ramp step", drive, p);
			p = drive;
		end
		chk("ramp end", drive, t);
		chk("ramp time", n >= lo, 1'b1);
		if (drive !== t) results();
	endtask

	// ==========================================================
	// scenarios
	task automatic s_scale();
		int sg[9] = '{500, 333, 100, 1000, 800, 690, 0, 200, 500};
		logic [3:0] al[9] = '{4'h0, 4'h0, 4'h8, 4'h5, 4'h5, 4'h0, 4'hA,
			4'h8, 4'h0};
		for (int i = 0; i < 9; i++) begin
			sample_valid = 1'b1;
			sample_signal = sg[i];
			@(negedge clk);
			sample_valid = 1'b0;
			chk("valid", valid, 1'b1);
			chk("value", chan, sg[i] * 100 / 1000 + 5);
			chk("alarms", in_al, al[i]);
			@(negedge clk);
		end
	endtask
	task automatic s_modes();
		oc.idle_action_sel = 1'b1;
		run_mode = 1'b0;
		cyc(4);
		chk("idle value", drive, 32'h1F4);
		run_mode = 1'b1;
		req(32'h64);
		chk("holding", holding, 1'b1);
		chk("held", drive, 32'h1F4);
		req(32'h1F4);
		chk("holding", holding, 1'b0);
		req(32'h4B0);
		chk("ceiling", drive, 32'h3E8);
		chk("flags", out_al, 3'h2);
		req(32'hFFFFFF38);
		chk("floor", drive, 32'hFFFFFF9C);
		chk("flags", out_al, 3'h4);
		req(32'h12C);
		chk("flags", out_al, 3'h0);
	endtask
	task automatic s_comm();
		oc.hold_until_matched = 1'b0;
		oc.comm_loss_action_sel = 1'b1;
		comm_ok = 1'b0;
		cyc(4);
		chk("loss value", drive, 32'h190);
		comm_ok = 1'b1;
		oc.comm_loss_action_sel = 1'b0;
		cyc(4);
		chk("back", drive, 32'h12C);
		comm_ok = 1'b0;
		req(32'h2BC);
		chk("loss hold", drive, 32'h12C);
		comm_ok = 1'b1;
		cyc(4);
		chk("applied", drive, 32'h2BC);
		oc.idle_action_sel = 1'b0;
		run_mode = 1'b0;
		req(32'hC8);
		chk("idle hold", drive, 32'h2BC);
		run_mode = 1'b1;
		cyc(4);
	endtask
	task automatic s_latch();
		oc.clamp_alarm_latch_en = 1'b1;
		req(32'hFFFFFF38);
		req(32'h4B0);
		req(32'h0);
		chk("latched", out_al, 3'h6);
		unl(scale_alarm_pkg::UNLATCH_FLOOR);
		chk("floor off", out_al, 3'h2);
		unl(scale_alarm_pkg::UNLATCH_CEILING);
		chk("ceiling off", out_al, 3'h0);
		req(32'hFFFFFF38);
		req(32'h0);
		chk("set again", out_al, 3'h4);
		// a busy sample stream must hold the service back
		sample_valid = 1'b1;
		sample_signal = 32'h1F4;
		fork
			unl(scale_alarm_pkg::UNLATCH_ALL);
			begin
				cyc(6);
				chk("deferred", out_al, 3'h4);
				chk("no done", unlatch_done, 1'b0);
				sample_valid = 1'b0;
			end
		join
		chk("all off", out_al, 3'h0);
	endtask
	task automatic s_ramp();
		oc.slew_in_run_en = 1'b1;
		oc.rate_alarm_latch_en = 1'b1;
		ctl.send(32'hC8);
		watch(32'hC8);
		chk("rate latched", out_al.rate_alarm_flag, 1'b1);
		unl(scale_alarm_pkg::UNLATCH_RATE);
		chk("rate off", out_al.rate_alarm_flag, 1'b0);
		oc.slew_to_idle_en = 1'b1;
		oc.idle_action_sel = 1'b1;
		oc.idle_output_value = 32'h6E;
		run_mode = 1'b0;
		watch(32'h6E);
		oc.slew_to_comm_loss_en = 1'b1;
		oc.comm_loss_action_sel = 1'b1;
		oc.comm_loss_output_value = 32'h0;
		comm_ok = 1'b0;
		watch(32'h0);
	endtask

	// ==========================================================
	// main sequence: reset for three cycles, then each scenario
	initial begin
		clk = 1'b0;
		reset_n = 1'b0;
		sample_valid = 1'b0;
		sample_signal = 32'h0;
		run_mode = 1'b1;
		comm_ok = 1'b1;
		ic = '0;
		ic.scale_signal_upper_point = 32'h3E8;
		ic.scale_eng_upper_point = 32'h64;
		ic.calibration_offset = 32'h5;
		ic.lo_alarm_threshold = 32'h14;
		ic.hi_alarm_threshold = 32'h50;
		ic.lolo_alarm_threshold = 32'hA;
		ic.hihi_alarm_threshold = 32'h5A;
		ic.alarm_hysteresis = 32'h5;
		oc = '0;
		oc.hold_until_matched = 1'b1;
		oc.slew_rate_limit = 16'h3E8;
		oc.comm_loss_output_value = 32'h190;
		oc.idle_output_value = 32'h1F4;
		oc.output_floor = 32'hFFFFFF9C;
		oc.output_ceiling = 32'h3E8;
		cyc(3);
		reset_n = 1'b1;
		cyc(2);
		s_scale();
		s_modes();
		s_comm();
		s_latch();
		s_ramp();
		results();
	end
endmodule // analog_channel_scale_alarm_ramp_tb_top
`default_nettype wire
